// >>> hw/spc_regs.sv
// Purpose: Lane PLL control/status register slice with reference predivider
// Assumes: Device register port: 12-bit address, 8-bit data, write and read strobes
// Notes:   Read data is registered, valid the cycle after rd_en
// What this block does
// - Equalizer power field bits 7:6, reset 01
// - Recalibrate bit rising edge starts calibration
// - Enable bit powers and calibrates PLL
// - Lock flag reports achieved PLL lock
// - Calibration-valid flag set after calibration completes
// - High overrange flag at band limit
// - Low overrange flag at lower band edge
// - Reference clock divided by selected factor
// - Code 00 divides by four, 10 by one
`timescale 1ns/1ps
`default_nettype none
module spc_regs
   import spc_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // Register port
   input  wire logic [SPC_AW-1:0] reg_addr,
   input  wire logic              reg_wr_en,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_rd_en,
   output logic      [7:0]        reg_rdata,
   // Analog PLL indications
   input  wire logic              pll_lock_in,
   input  wire logic              pll_band_high_in,
   input  wire logic              pll_band_low_in,
   // Lane PLL controls
   output logic                   pll_power_on,
   output logic                   pll_cal_run,
   output logic      [1:0]        equalizer_power_select,
   output logic      [5:0]        eq_bias_trim,
   output logic      [7:0]        pll_lf_a,
   output logic      [7:0]        pll_lf_b,
   output logic      [7:0]        pll_lf_c,
   output logic      [7:0]        pll_pump_a,
   output logic      [7:0]        pll_osc_reg,
   output logic      [7:0]        pll_pd_a,
   output logic      [7:0]        pll_var_a,
   output logic                   ref_cfg4,
   // Reference clock predivider
   input  wire logic              ref_clk_in,
   output logic                   ref_clk_div
);
   spc_cal_if cal ();

   logic [7:0] eq_q, eq_d, lfa_q, lfa_d, lfb_q, lfb_d, lfc_q, lfc_d;
   logic [7:0] pump_q, pump_d, osc_q, osc_d, pd_q, pd_d, var_q, var_d;
   logic [2:0] refdiv_q, refdiv_d;
   logic       on_q, on_d, recal_q, recal_d, recal_old_q;
   logic [7:0] rdata_q, rdata_d;
   logic [1:0] dcnt_q, dcnt_d;
   logic       dout_q, dout_d, ref_old_q;
   logic       ref_rise;
   logic [2:0] factor;

   function automatic logic hit(input logic [SPC_AW-1:0] ofs);
      hit = reg_wr_en && (reg_addr == ofs);
   endfunction

   always_comb begin
      eq_d     = hit(SPC_OFS_EQ)      ? reg_wdata : eq_q;
      lfa_d    = hit(SPC_OFS_LF_A)    ? reg_wdata : lfa_q;
      lfb_d    = hit(SPC_OFS_LF_B)    ? reg_wdata : lfb_q;
      lfc_d    = hit(SPC_OFS_LF_C)    ? reg_wdata : lfc_q;
      pump_d   = hit(SPC_OFS_PUMP_A)  ? reg_wdata : pump_q;
      osc_d    = hit(SPC_OFS_OSC_REG) ? reg_wdata : osc_q;
      pd_d     = hit(SPC_OFS_PD_A)    ? reg_wdata : pd_q;
      var_d    = hit(SPC_OFS_VAR_A)   ? reg_wdata : var_q;
      refdiv_d = hit(SPC_OFS_REFDIV)  ? reg_wdata[2:0] : refdiv_q;
      on_d     = hit(SPC_OFS_EN)      ? reg_wdata[SPC_BIT_TURN_ON] : on_q;
      recal_d  = hit(SPC_OFS_EN)      ? reg_wdata[SPC_BIT_RECAL] : recal_q;
      rdata_d  = rdata_q;
      if (reg_rd_en) begin
         case (reg_addr)
            SPC_OFS_EQ:      rdata_d = eq_q;
            SPC_OFS_EN:      rdata_d = {5'h00, recal_q, 1'b0, on_q};
            SPC_OFS_FLAGS:   rdata_d = {2'h0, cal.band_high, cal.band_low,
                                        cal.calibrated, 2'h0, cal.locked};
            SPC_OFS_LF_A:    rdata_d = lfa_q;
            SPC_OFS_LF_B:    rdata_d = lfb_q;
            SPC_OFS_LF_C:    rdata_d = lfc_q;
            SPC_OFS_PUMP_A:  rdata_d = pump_q;
            SPC_OFS_REFDIV:  rdata_d = {5'h00, refdiv_q};
            SPC_OFS_OSC_REG: rdata_d = osc_q;
            SPC_OFS_PD_A:    rdata_d = pd_q;
            SPC_OFS_VAR_A:   rdata_d = var_q;
            default:         rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         eq_q        <= SPC_RST_EQ;
         lfa_q       <= SPC_RST_LF_A;
         lfb_q       <= SPC_RST_LF_B;
         lfc_q       <= SPC_RST_LF_C;
         pump_q      <= SPC_RST_PUMP_A;
         osc_q       <= SPC_RST_OSC_REG;
         pd_q        <= SPC_RST_PD_A;
         var_q       <= SPC_RST_VAR_A;
         refdiv_q    <= SPC_RST_REFDIV;
         on_q        <= 1'b0;
         recal_q     <= 1'b0;
         recal_old_q <= 1'b0;
         rdata_q     <= 8'h00;
      end else begin
         eq_q        <= eq_d;
         lfa_q       <= lfa_d;
         lfb_q       <= lfb_d;
         lfc_q       <= lfc_d;
         pump_q      <= pump_d;
         osc_q       <= osc_d;
         pd_q        <= pd_d;
         var_q       <= var_d;
         refdiv_q    <= refdiv_d;
         on_q        <= on_d;
         recal_q     <= recal_d;
         recal_old_q <= recal_q;
         rdata_q     <= rdata_d;
      end
   end

   // Edge, not level, of the recalibrate bit
   assign cal.turn_on   = on_q;
   assign cal.start_cal = recal_q && !recal_old_q;

   spc_cal_seq u_seq (
      .clk_sys          (clk_sys),
      .reset            (reset),
      .cal              (cal),
      .pll_lock_in      (pll_lock_in),
      .pll_band_high_in (pll_band_high_in),
      .pll_band_low_in  (pll_band_low_in),
      .pll_power_on     (pll_power_on),
      .pll_cal_run      (pll_cal_run)
   );

   // Reference predivider; ref_clk_in sampled as a synchronous input
   assign factor   = spc_div_factor(refdiv_q[1:0]);
   assign ref_rise = ref_clk_in && !ref_old_q;

   always_comb begin
      dcnt_d = dcnt_q;
      dout_d = dout_q;
      case (factor)
         3'h1: dout_d = ref_clk_in;
         3'h2: if (ref_rise) dout_d = !dout_q;
         default: begin
            if (ref_rise) begin
               dcnt_d = dcnt_q + 2'h1;
               if (dcnt_q[0]) dout_d = !dout_q;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dcnt_q    <= 2'h0;
         dout_q    <= 1'b0;
         ref_old_q <= 1'b0;
      end else begin
         dcnt_q    <= dcnt_d;
         dout_q    <= dout_d;
         ref_old_q <= ref_clk_in;
      end
   end

   assign reg_rdata              = rdata_q;
   assign ref_clk_div            = dout_q;
   assign equalizer_power_select = eq_q[7:6];
   assign eq_bias_trim           = eq_q[5:0];
   assign pll_lf_a               = lfa_q;
   assign pll_lf_b               = lfb_q;
   assign pll_lf_c               = lfc_q;
   assign pll_pump_a             = pump_q;
   assign pll_osc_reg            = osc_q;
   assign pll_pd_a               = pd_q;
   assign pll_var_a              = var_q;
   assign ref_cfg4               = refdiv_q[SPC_BIT_CFG4];

   property p_eq_reset;
      @(posedge clk_sys) $fell(reset) |-> equalizer_power_select == SPC_EQ_LOWPWR;
   endproperty
   a_eq_reset: assert property (p_eq_reset) else $error("Eq power reset wrong");

   sequence s_recal_rise;
      reg_wr_en && reg_addr == SPC_OFS_EN && reg_wdata[SPC_BIT_RECAL] && !recal_q
         && on_q && reg_wdata[SPC_BIT_TURN_ON];
   endsequence
   property p_recal;
      @(posedge clk_sys) disable iff (reset)
      s_recal_rise |=> ##1 pll_cal_run;
   endproperty
   a_recal: assert property (p_recal) else $error("Recal edge ignored");

   property p_no_retrigger;
      @(posedge clk_sys) disable iff (reset)
      (recal_q && recal_old_q && on_q && pll_power_on && !pll_cal_run) |=> !pll_cal_run;
   endproperty
   a_no_retrigger: assert property (p_no_retrigger) else $error("Level retriggered");

   property p_flags_ro;
      @(posedge clk_sys) disable iff (reset)
      (reg_rd_en && reg_addr == SPC_OFS_FLAGS) |=> reg_rdata[7:6] == 2'h0
         && reg_rdata[2:1] == 2'h0;
   endproperty
   a_flags_ro: assert property (p_flags_ro) else $error("Reserved flag bits set");

   property p_div1;
      @(posedge clk_sys) disable iff (reset)
      (refdiv_q[1:0] == SPC_DIV_BY1 && $stable(refdiv_q)) |=> ref_clk_div == $past(ref_clk_in);
   endproperty
   a_div1: assert property (p_div1) else $error("Divide by one wrong");
endmodule
`default_nettype wire

// >>> hw/spc_pkg.sv
// Purpose: Constants for the lane PLL control and status register slice
// Assumes: 8-bit registers at 12-bit byte addresses
// Notes:   Reset values and field positions live here only
package spc_pkg;
   localparam int          SPC_AW = 12;
   localparam logic [11:0] SPC_OFS_EQ      = 12'h268;
   localparam logic [11:0] SPC_OFS_EN      = 12'h280;
   localparam logic [11:0] SPC_OFS_FLAGS   = 12'h281;
   localparam logic [11:0] SPC_OFS_LF_A    = 12'h284;
   localparam logic [11:0] SPC_OFS_LF_B    = 12'h285;
   localparam logic [11:0] SPC_OFS_LF_C    = 12'h286;
   localparam logic [11:0] SPC_OFS_PUMP_A  = 12'h287;
   localparam logic [11:0] SPC_OFS_REFDIV  = 12'h289;
   localparam logic [11:0] SPC_OFS_OSC_REG = 12'h28a;
   localparam logic [11:0] SPC_OFS_PD_A    = 12'h28b;
   localparam logic [11:0] SPC_OFS_VAR_A   = 12'h290;

   localparam logic [7:0] SPC_RST_EQ      = 8'h62;  // Power select 01, low bits 22
   localparam logic [7:0] SPC_RST_LF_A    = 8'h77;
   localparam logic [7:0] SPC_RST_LF_B    = 8'h87;
   localparam logic [7:0] SPC_RST_LF_C    = 8'h08;
   localparam logic [7:0] SPC_RST_PUMP_A  = 8'h3f;
   localparam logic [7:0] SPC_RST_OSC_REG = 8'h2b;
   localparam logic [7:0] SPC_RST_PD_A    = 8'h7f;
   localparam logic [7:0] SPC_RST_VAR_A   = 8'h83;
   localparam logic [2:0] SPC_RST_REFDIV  = 3'h0;

   localparam int SPC_BIT_TURN_ON = 0;
   localparam int SPC_BIT_RECAL   = 2;
   localparam int SPC_BIT_LOCK    = 0;
   localparam int SPC_BIT_CALOK   = 3;
   localparam int SPC_BIT_BAND_LO = 4;
   localparam int SPC_BIT_BAND_HI = 5;
   localparam int SPC_BIT_CFG4    = 2;
   localparam logic [1:0] SPC_EQ_NORMAL = 2'h0;
   localparam logic [1:0] SPC_EQ_LOWPWR = 2'h1;
   localparam logic [1:0] SPC_DIV_BY4   = 2'h0;
   localparam logic [1:0] SPC_DIV_BY2   = 2'h1;
   localparam logic [1:0] SPC_DIV_BY1   = 2'h2;

   // Calibration sequencer timing, in clk_sys cycles
   localparam logic [7:0] SPC_CAL_CYCLES = 8'h40;

   typedef enum logic [3:0] {
      SPC_ST_OFF   = 4'b0001,
      SPC_ST_CAL   = 4'b0010,
      SPC_ST_RUN   = 4'b0100,
      SPC_ST_FAULT = 4'b1000
   } spc_state_e;

   // Divide factor for a predivider code
   function automatic logic [2:0] spc_div_factor(input logic [1:0] code);
      case (code)
         SPC_DIV_BY4: spc_div_factor = 3'h4;
         SPC_DIV_BY2: spc_div_factor = 3'h2;
         SPC_DIV_BY1: spc_div_factor = 3'h1;
         default:     spc_div_factor = 3'h1;
      endcase
   endfunction
endpackage

// >>> hw/spc_cal_if.sv
// Purpose: Carrier between register slice and calibration sequencer
// Assumes: One clock domain
// Notes:   Status flags travel from sequencer to registers
`timescale 1ns/1ps
`default_nettype none
interface spc_cal_if;
   logic turn_on;
   logic start_cal;
   logic locked;
   logic calibrated;
   logic band_high;
   logic band_low;
   modport regs (output turn_on, output start_cal,
                 input locked, input calibrated, input band_high, input band_low);
   modport seq  (input turn_on, input start_cal,
                 output locked, output calibrated, output band_high, output band_low);
endinterface
`default_nettype wire

// >>> hw/spc_cal_seq.sv
// Purpose: Lane PLL power-up and calibration sequencer
// Assumes: Analog lock/band indications are synchronous to clk_sys
// Notes:   Fault state holds band flags until a recalibration or until the enable bit is cleared
`timescale 1ns/1ps
`default_nettype none
module spc_cal_seq
   import spc_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   // Register side
   spc_cal_if.seq    cal,
   // Analog PLL indications
   input  wire logic pll_lock_in,
   input  wire logic pll_band_high_in,
   input  wire logic pll_band_low_in,
   // Analog PLL controls
   output logic      pll_power_on,
   output logic      pll_cal_run
);
   spc_state_e state_q, state_d;
   logic [7:0] cnt_q, cnt_d;
   logic       calok_q, calok_d;
   logic       hi_q, hi_d, lo_q, lo_d;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      calok_d = calok_q;
      hi_d    = hi_q;
      lo_d    = lo_q;
      case (state_q)
         SPC_ST_OFF: begin
            if (cal.turn_on) begin
               state_d = SPC_ST_CAL;
               cnt_d   = SPC_CAL_CYCLES;
            end
         end
         SPC_ST_CAL: begin
            calok_d = 1'b0;
            hi_d    = 1'b0;
            lo_d    = 1'b0;
            if (cnt_q != 8'h00) begin
               cnt_d = cnt_q - 8'h01;
            end else begin
               state_d = SPC_ST_RUN;
               calok_d = 1'b1;
            end
         end
         SPC_ST_RUN: begin
            hi_d = hi_q | pll_band_high_in;
            lo_d = lo_q | pll_band_low_in;
            if (pll_band_high_in || pll_band_low_in) begin
               state_d = SPC_ST_FAULT;
            end
         end
         SPC_ST_FAULT: ;
         default: state_d = SPC_ST_OFF;
      endcase
      if (state_q != SPC_ST_OFF && cal.start_cal) begin
         state_d = SPC_ST_CAL;
         cnt_d   = SPC_CAL_CYCLES;
      end
      if (!cal.turn_on) begin
         state_d = SPC_ST_OFF;
         calok_d = 1'b0;
         hi_d    = 1'b0;
         lo_d    = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= SPC_ST_OFF;
         cnt_q   <= 8'h00;
         calok_q <= 1'b0;
         hi_q    <= 1'b0;
         lo_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         calok_q <= calok_d;
         hi_q    <= hi_d;
         lo_q    <= lo_d;
      end
   end

   assign pll_power_on   = (state_q != SPC_ST_OFF);
   assign pll_cal_run    = (state_q == SPC_ST_CAL);
   assign cal.calibrated = calok_q;
   assign cal.band_high  = hi_q;
   assign cal.band_low   = lo_q;
   assign cal.locked     = pll_lock_in && calok_q;

   property p_cal_done;
      @(posedge clk_sys) disable iff (reset)
      (state_q == SPC_ST_CAL && cnt_q == 8'h00 && cal.turn_on && !cal.start_cal)
         |=> calok_q;
   endproperty
   a_cal_done: assert property (p_cal_done) else $error("Cal valid not set");

   property p_enable_cal;
      @(posedge clk_sys) disable iff (reset)
      (state_q == SPC_ST_OFF && cal.turn_on) |=> pll_cal_run && pll_power_on;
   endproperty
   a_enable_cal: assert property (p_enable_cal) else $error("Enable did not calibrate");

   property p_band_hi;
      @(posedge clk_sys) disable iff (reset)
      (state_q == SPC_ST_RUN && pll_band_high_in && cal.turn_on && !cal.start_cal)
         |=> cal.band_high;
   endproperty
   a_band_hi: assert property (p_band_hi) else $error("High band flag missing");

   property p_band_lo;
      @(posedge clk_sys) disable iff (reset)
      (state_q == SPC_ST_RUN && pll_band_low_in && cal.turn_on && !cal.start_cal)
         |=> cal.band_low;
   endproperty
   a_band_lo: assert property (p_band_lo) else $error("Low band flag missing");

   property p_lock;
      @(posedge clk_sys) disable iff (reset)
      (state_q == SPC_ST_RUN && pll_lock_in) |-> cal.locked;
   endproperty
   a_lock: assert property (p_lock) else $error("Lock flag missing while locked");
endmodule
`default_nettype wire

// >>> test/spc_tb.sv
// Purpose: Self-checking bench for the lane PLL register slice
// Assumes: Inputs change 1 ns after the rising edge of clk_sys
// Notes:   Predivider judged by the measured period of its output
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import spc_pkg::*;
   logic              clk_sys;
   logic              reset;
   logic [SPC_AW-1:0] reg_addr;
   logic              reg_wr_en;
   logic [7:0]        reg_wdata;
   logic              reg_rd_en;
   logic [7:0]        reg_rdata;
   logic              pll_lock_in;
   logic              pll_band_high_in;
   logic              pll_band_low_in;
   logic              pll_power_on;
   logic              pll_cal_run;
   logic [1:0]        equalizer_power_select;
   logic [5:0]        eq_bias_trim;
   logic [7:0]        pll_lf_a;
   logic [7:0]        pll_lf_b;
   logic [7:0]        pll_lf_c;
   logic [7:0]        pll_pump_a;
   logic [7:0]        pll_osc_reg;
   logic [7:0]        pll_pd_a;
   logic [7:0]        pll_var_a;
   logic              ref_cfg4;
   logic              ref_clk_in;
   logic              ref_clk_div;
   int                bad_count;
   int                samples_checked;
   int                ref_cnt;

   localparam logic [11:0] MAP_A [11] = '{SPC_OFS_EQ, SPC_OFS_EN, SPC_OFS_FLAGS, SPC_OFS_LF_A,
      SPC_OFS_LF_B, SPC_OFS_LF_C, SPC_OFS_PUMP_A, SPC_OFS_REFDIV, SPC_OFS_OSC_REG,
      SPC_OFS_PD_A, SPC_OFS_VAR_A};
   localparam logic [7:0] RST_V [11] = '{8'h62, 8'h00, 8'h00, 8'h77, 8'h87, 8'h08, 8'h3f,
      8'h00, 8'h2b, 8'h7f, 8'h83};
   localparam logic [7:0] NEW_V [11] = '{8'h22, 8'h00, 8'h00, 8'h62, 8'hc9, 8'h0e, 8'h12,
      8'h06, 8'h7b, 8'h00, 8'h89};

   spc_regs dut (.clk_sys, .reset, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
      .pll_lock_in, .pll_band_high_in, .pll_band_low_in, .pll_power_on, .pll_cal_run,
      .equalizer_power_select, .eq_bias_trim, .pll_lf_a, .pll_lf_b, .pll_lf_c, .pll_pump_a,
      .pll_osc_reg, .pll_pd_a, .pll_var_a, .ref_cfg4, .ref_clk_in, .ref_clk_div);

   always #4 clk_sys = ~clk_sys;

   // Reference at one eighth of clk_sys
   always @(posedge clk_sys) begin
      #1;
      ref_cnt = ref_cnt + 1;
      if (ref_cnt == 4) begin
         ref_cnt = 0;
         ref_clk_in = ~ref_clk_in;
      end
   end

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      tick(1);
      reg_wr_en = 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_rd_en = 1'b1;
      tick(1);
      reg_rd_en = 1'b0;
      d = reg_rdata;
   endtask

   // Counts remaining calibration cycles, bounded
   task automatic wait_cal(output int n);
      int i;
      n = 0;
      for (i = 0; i < 300; i++) begin
         tick(1);
         if (pll_cal_run === 1'b1) n++;
         else if (n > 0) return;
      end
      bad_count++;
      end_sim();
   endtask

   task automatic t_reset;
      logic [7:0] v;
      for (int i = 0; i < 11; i++) begin
         rd(MAP_A[i], v);
         chk("reset_value", v, RST_V[i]);
      end
      chk("eq_sel_rst", {6'h00, equalizer_power_select}, 8'h01);
   endtask

   task automatic t_program;
      logic [7:0] v;
      for (int i = 0; i < 11; i++) begin
         if (i > 2) wr(MAP_A[i], NEW_V[i]);
      end
      wr(SPC_OFS_EQ, 8'h22);
      for (int i = 0; i < 11; i++) begin
         rd(MAP_A[i], v);
         chk("readback", v, NEW_V[i]);
      end
      chk("eq_sel_norm", {6'h00, equalizer_power_select}, 8'h00);
      chk("eq_trim", {2'h0, eq_bias_trim}, 8'h22);
      chk("lf_a", pll_lf_a, 8'h62);
      chk("lf_b", pll_lf_b, 8'hc9);
      chk("lf_c", pll_lf_c, 8'h0e);
      chk("pump_a", pll_pump_a, 8'h12);
      chk("osc_reg", pll_osc_reg, 8'h7b);
      chk("pd_a", pll_pd_a, 8'h00);
      chk("pd_var", pll_pd_a ^ pll_var_a, 8'h89);
      chk("cfg4", {7'h00, ref_cfg4}, 8'h01);
      wr(SPC_OFS_EQ, 8'h62);
      tick(1);
      chk("eq_sel_low", {6'h00, equalizer_power_select}, 8'h01);
   endtask

   task automatic t_readonly;
      logic [7:0] v;
      wr(SPC_OFS_FLAGS, 8'hff);
      wr(SPC_OFS_EN, 8'hfa);
      wr(12'h282, 8'h55);
      rd(SPC_OFS_FLAGS, v);
      chk("flags_ro", v, 8'h00);
      rd(SPC_OFS_EN, v);
      chk("en_reserved", v, 8'h00);
      rd(12'h282, v);
      chk("unmapped", v, 8'h00);
      chk("no_power", {7'h00, pll_power_on}, 8'h00);
   endtask

   task automatic t_cal;
      logic [7:0] v;
      int n;
      pll_lock_in = 1'b1;
      wr(SPC_OFS_EN, 8'h01);
      tick(3);
      chk("power_on", {7'h00, pll_power_on}, 8'h01);
      chk("cal_run", {7'h00, pll_cal_run}, 8'h01);
      rd(SPC_OFS_FLAGS, v);
      chk("flags_mid", v, 8'h00);
      wait_cal(n);
      // Calibration lasts SPC_CAL_CYCLES + 1; five cycles already seen above
      chk("cal_long", n[7:0], SPC_CAL_CYCLES - 8'h04);
      rd(SPC_OFS_FLAGS, v);
      chk("flags_lock", v, 8'h09);
      pll_lock_in = 1'b0;
      rd(SPC_OFS_FLAGS, v);
      chk("flags_unlock", v, 8'h08);
   endtask

   task automatic t_band;
      logic [7:0] v;
      int n;
      pll_band_high_in = 1'b1;
      tick(2);
      pll_band_high_in = 1'b0;
      rd(SPC_OFS_FLAGS, v);
      chk("band_high", v & 8'h30, 8'h20);
      wr(SPC_OFS_EN, 8'h05);
      tick(3);
      chk("recal_run", {7'h00, pll_cal_run}, 8'h01);
      rd(SPC_OFS_FLAGS, v);
      chk("band_cleared", v & 8'h38, 8'h00);
      wait_cal(n);
      wr(SPC_OFS_EN, 8'h05);
      tick(4);
      chk("recal_steady", {7'h00, pll_cal_run}, 8'h00);
      pll_band_low_in = 1'b1;
      tick(2);
      pll_band_low_in = 1'b0;
      rd(SPC_OFS_FLAGS, v);
      chk("band_low", v & 8'h30, 8'h10);
      wr(SPC_OFS_EN, 8'h00);
      tick(2);
      rd(SPC_OFS_FLAGS, v);
      chk("flags_off", v, 8'h00);
      chk("power_off", {7'h00, pll_power_on}, 8'h00);
   endtask

   // Clock cycles between two rising edges of the divided reference
   task automatic measure(output int per);
      logic prev;
      int   t0;
      t0 = -1;
      prev = ref_clk_div;
      for (int i = 0; i < 200; i++) begin
         tick(1);
         if (ref_clk_div === 1'b1 && prev === 1'b0) begin
            if (t0 >= 0) begin
               per = i - t0;
               return;
            end
            t0 = i;
         end
         prev = ref_clk_div;
      end
      bad_count++;
      end_sim();
   endtask

   task automatic t_div;
      logic [7:0] exp_p [4];
      int per;
      exp_p = '{8'h20, 8'h10, 8'h08, 8'h08};
      for (int k = 0; k < 4; k++) begin
         // Reference is a scaled stand-in; each code stays in the detector window
         wr(SPC_OFS_REFDIV, {6'h01, k[1:0]});
         tick(80);
         measure(per);
         chk("div_period", per[7:0], exp_p[k]);
      end
   endtask

   initial begin
      clk_sys = 1'b0;
      reset = 1'b1;
      reg_addr = 12'h000;
      reg_wr_en = 1'b0;
      reg_wdata = 8'h00;
      reg_rd_en = 1'b0;
      pll_lock_in = 1'b0;
      pll_band_high_in = 1'b0;
      pll_band_low_in = 1'b0;
      ref_clk_in = 1'b0;
      ref_cnt = 0;
      bad_count = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      t_reset();
      t_program();
      t_readonly();
      t_cal();
      t_band();
      t_div();
      end_sim();
   end
endmodule
`default_nettype wire
